// ==== design/dph_ctrl.sv ====
// dpll holdover history, fixed/incremental phase offset and slew limiter with apb registers
`timescale 1ns/1ps
`default_nettype none

module dph_ctrl #(
  parameter int unsigned MS_CYCLES = dph_pkg::MS_CYCLES_DEF  // clocks per millisecond
) (
  input  wire logic                   pclk,          // system clock, 10 MHz
  input  wire logic                   presetn,       // async reset, active low
  input  wire logic                   psel,          // apb select
  input  wire logic                   penable,       // apb enable
  input  wire logic                   pwrite,        // apb write
  input  wire logic [15:0]            paddr,         // apb byte address
  input  wire logic [31:0]            pwdata,        // apb write data
  output logic                        pready,        // apb ready
  output logic [31:0]                 prdata,        // apb read data
  output logic                        pslverr,       // apb error on unmapped
  input  wire dph_pkg::dph_tword_t    loop_tword,    // live loop tuning word
  input  wire logic [29:0]            free_run_word, // stored free-running word
  input  wire logic                   ref_switch,    // pulse: new reference chosen
  input  wire logic                   hold_enter,    // pulse: holdover entered
  input  wire logic                   loop_locked,   // level: loop is locked
  input  wire logic                   step_up,       // pulse: add one phase step
  input  wire logic                   step_down,     // pulse: subtract one phase step
  output logic [29:0]                 hold_word,     // tuning word used in holdover
  output dph_pkg::dph_hold_src_t      hold_src,      // where hold_word came from
  output logic                        hist_valid,    // history exists
  output logic                        hist_update,   // pulse: history refreshed
  output logic [29:0]                 phase_offset,  // slewed signed offset, ps
  output logic                        slewing        // offset still moving
);

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic [15:0]            hist_tmr;
  dph_pkg::dph_hist_cfg_t hist_cfg;
  logic [29:0]            fix_phase;
  logic [15:0]            step_size;
  logic [15:0]            slew_limit;

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic [13:0] idx;
  logic        aligned;
  logic        acc;
  logic        wr_go;
  logic        hit_tmr_lo;
  logic        hit_tmr_hi;
  logic        hit_mode;
  logic        hit_fp0;
  logic        hit_fp1;
  logic        hit_fp2;
  logic        hit_fp3;
  logic        hit_st_lo;
  logic        hit_st_hi;
  logic        hit_sl_lo;
  logic        hit_sl_hi;
  logic        hit_status;
  logic        hit_hold0;
  logic        hit_hold1;
  logic        hit_hold2;
  logic        hit_hold3;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;
  logic [7:0]  status_byte;
  logic        sched_first_done;

  assign idx        = paddr[15:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  // access phase; the answer comes one cycle into it, from a flop
  assign acc        = psel && penable;
  assign wr_go      = acc && pready && pwrite && mapped;
  assign wbyte      = pwdata[7:0];
  assign hit_tmr_lo = aligned && (idx == dph_pkg::IDX_HIST_TMR_LO);
  assign hit_tmr_hi = aligned && (idx == dph_pkg::IDX_HIST_TMR_HI);
  assign hit_mode   = aligned && (idx == dph_pkg::IDX_HIST_MODE);
  assign hit_fp0    = aligned && (idx == dph_pkg::IDX_FIX_PH_B0);
  assign hit_fp1    = aligned && (idx == dph_pkg::IDX_FIX_PH_B1);
  assign hit_fp2    = aligned && (idx == dph_pkg::IDX_FIX_PH_B2);
  assign hit_fp3    = aligned && (idx == dph_pkg::IDX_FIX_PH_B3);
  assign hit_st_lo  = aligned && (idx == dph_pkg::IDX_STEP_LO);
  assign hit_st_hi  = aligned && (idx == dph_pkg::IDX_STEP_HI);
  assign hit_sl_lo  = aligned && (idx == dph_pkg::IDX_SLEW_LO);
  assign hit_sl_hi  = aligned && (idx == dph_pkg::IDX_SLEW_HI);
  assign hit_status = aligned && (idx == dph_pkg::IDX_STATUS);
  assign hit_hold0  = aligned && (idx == dph_pkg::IDX_HOLD_B0);
  assign hit_hold1  = aligned && (idx == dph_pkg::IDX_HOLD_B1);
  assign hit_hold2  = aligned && (idx == dph_pkg::IDX_HOLD_B2);
  assign hit_hold3  = aligned && (idx == dph_pkg::IDX_HOLD_B3);
  assign mapped     = hit_tmr_lo | hit_tmr_hi | hit_mode | hit_fp0 | hit_fp1 | hit_fp2 |
                      hit_fp3 | hit_st_lo | hit_st_hi | hit_sl_lo | hit_sl_hi | hit_status |
                      hit_hold0 | hit_hold1 | hit_hold2 | hit_hold3;

  assign status_byte = {3'b000, hold_src, slewing, sched_first_done, hist_valid};

  // multi-byte fields: lowest index carries the least significant byte
  assign rd_byte = hit_tmr_lo ? hist_tmr[7:0] :
                   hit_tmr_hi ? hist_tmr[15:8] :
                   hit_mode   ? {3'b000, hist_cfg} :
                   hit_fp0    ? fix_phase[7:0] :
                   hit_fp1    ? fix_phase[15:8] :
                   hit_fp2    ? fix_phase[23:16] :
                   hit_fp3    ? {2'b00, fix_phase[29:24]} :
                   hit_st_lo  ? step_size[7:0] :
                   hit_st_hi  ? step_size[15:8] :
                   hit_sl_lo  ? slew_limit[7:0] :
                   hit_sl_hi  ? slew_limit[15:8] :
                   hit_status ? status_byte :
                   hit_hold0  ? hold_word[7:0] :
                   hit_hold1  ? hold_word[15:8] :
                   hit_hold2  ? hold_word[23:16] :
                   hit_hold3  ? {2'b00, hold_word[29:24]} :
                   8'h00;

  // one wait state: pready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready;
      prdata  <= (acc && !pready && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr <= acc && !pready && !mapped;
    end
  end

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_tmr   <= dph_pkg::HIST_TMR_RST;
      hist_cfg   <= dph_pkg::dph_hist_cfg_t'(dph_pkg::HIST_MODE_RST[4:0]);
      fix_phase  <= dph_pkg::FIX_PH_RST;
      step_size  <= dph_pkg::STEP_RST;
      slew_limit <= dph_pkg::SLEW_RST;
    end else if (wr_go) begin
      if (hit_tmr_lo) hist_tmr[7:0] <= wbyte;
      if (hit_tmr_hi) hist_tmr[15:8] <= wbyte;
      if (hit_mode) hist_cfg <= dph_pkg::dph_hist_cfg_t'(wbyte[4:0] & dph_pkg::MODE_MASK[4:0]);
      if (hit_fp0) fix_phase[7:0] <= wbyte;
      if (hit_fp1) fix_phase[15:8] <= wbyte;
      if (hit_fp2) fix_phase[23:16] <= wbyte;
      if (hit_fp3) fix_phase[29:24] <= wbyte[5:0] & dph_pkg::TOP6_MASK[5:0];
      if (hit_st_lo) step_size[7:0] <= wbyte;
      if (hit_st_hi) step_size[15:8] <= wbyte;
      if (hit_sl_lo) slew_limit[7:0] <= wbyte;
      if (hit_sl_hi) slew_limit[15:8] <= wbyte;
    end
  end

  // ------------------------------------------------------------
  // millisecond and microsecond strobes
  // ------------------------------------------------------------
  logic [15:0] ms_cnt;
  logic        ms_tick;
  logic [3:0]  us_cnt;
  logic        us_tick;

  assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
  assign us_tick = (us_cnt == (dph_pkg::US_CYCLES - 4'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt <= 16'h0000;
      us_cnt <= 4'h0;
    end else begin
      ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
      us_cnt <= us_tick ? 4'h0 : us_cnt + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // tuning-word averaging and history
  // ------------------------------------------------------------
  logic        clear_hist;
  logic        sched_update;
  logic [29:0] avg_word;
  logic        avg_seeded;
  logic [30:0] avg_diff;
  logic [29:0] next_avg;
  logic [29:0] hist_word;
  logic [29:0] last_loop;
  logic        loop_seen;

  assign clear_hist = ref_switch && !hist_cfg.persist;

  dph_hist_sched u_sched (
    .pclk       (pclk),
    .presetn    (presetn),
    .ms_tick    (ms_tick),
    .restart    (clear_hist),
    .interval   (hist_tmr),
    .inc_avg    (hist_cfg.inc_avg),
    .update     (sched_update),
    .first_done (sched_first_done)
  );

  // first-order average, half weight per millisecond sample; cheap and needs no divider
  assign avg_diff = {loop_tword.word[29], loop_tword.word} - {avg_word[29], avg_word};
  assign next_avg = avg_word + avg_diff[30:1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_word   <= 30'h00000000;
      avg_seeded <= 1'b0;
      last_loop  <= 30'h00000000;
      loop_seen  <= 1'b0;
    end else begin
      if (loop_tword.valid) begin
        last_loop <= loop_tword.word;
        loop_seen <= 1'b1;
      end
      if (clear_hist) begin
        avg_seeded <= 1'b0;
      end else if (ms_tick && loop_tword.valid) begin
        avg_word   <= avg_seeded ? next_avg : loop_tword.word;
        avg_seeded <= 1'b1;
      end
    end
  end

  // a fresh update wins over a clear arriving in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_word   <= 30'h00000000;
      hist_valid  <= 1'b0;
      hist_update <= 1'b0;
    end else begin
      hist_update <= sched_update && avg_seeded;
      if (sched_update && avg_seeded) begin
        hist_word  <= avg_word;
        hist_valid <= 1'b1;
      end else if (clear_hist) begin
        hist_valid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // holdover word selection
  // ------------------------------------------------------------
  logic [29:0]            sel_word;
  dph_pkg::dph_hold_src_t sel_src;

  assign sel_src  = hist_valid ? dph_pkg::DPH_SRC_HISTORY :
                    (hist_cfg.fallback && loop_seen) ? dph_pkg::DPH_SRC_LOOP :
                    dph_pkg::DPH_SRC_FREERUN;
  assign sel_word = hist_valid ? hist_word :
                    (hist_cfg.fallback && loop_seen) ? last_loop : free_run_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_word <= 30'h00000000;
      hold_src  <= dph_pkg::DPH_SRC_NONE;
    end else if (hold_enter) begin
      hold_word <= sel_word;
      hold_src  <= sel_src;
    end
  end

  // ------------------------------------------------------------
  // phase offset target and slew limiter
  // ------------------------------------------------------------
  logic [29:0] step_acc;
  logic [29:0] target;
  logic [30:0] ph_diff;
  logic [30:0] lim_ext;
  logic        over_up;
  logic        over_dn;
  logic [29:0] next_phase;

  // steps only count while the loop is locked; zero size leaves offset alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_acc <= 30'h00000000;
    end else if (loop_locked && (step_up != step_down)) begin
      step_acc <= step_up ? step_acc + {14'h0000, step_size} :
                            step_acc - {14'h0000, step_size};
    end
  end

  assign target  = fix_phase + step_acc;
  assign ph_diff = {target[29], target} - {phase_offset[29], phase_offset};
  // 1 us/s of slew equals 1 ps of movement per microsecond
  assign lim_ext = {15'h0000, slew_limit};
  assign over_up = !ph_diff[30] && (ph_diff > lim_ext);
  assign over_dn = ph_diff[30] && ((31'h00000000 - ph_diff) > lim_ext);

  assign next_phase = (slew_limit == 16'h0000) ? target :
                      !us_tick ? phase_offset :
                      over_up ? phase_offset + {14'h0000, slew_limit} :
                      over_dn ? phase_offset - {14'h0000, slew_limit} :
                      target;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_offset <= dph_pkg::FIX_PH_RST;
      slewing      <= 1'b0;
    end else begin
      phase_offset <= next_phase;
      slewing      <= (next_phase != target);
    end
  end

endmodule

`default_nettype wire

// ==== design/dph_hist_sched.sv ====
// history update scheduler: full-interval and early fractional update points
`timescale 1ns/1ps
`default_nettype none

module dph_hist_sched (
  input  wire logic        pclk,       // system clock
  input  wire logic        presetn,    // async reset, active low
  input  wire logic        ms_tick,    // one-cycle millisecond strobe
  input  wire logic        restart,    // start a fresh first interval
  input  wire logic [15:0] interval,   // full averaging interval in ms
  input  wire logic [2:0]  inc_avg,    // incremental-average setting
  output logic             update,     // one-cycle history update pulse
  output logic             first_done  // first full interval completed
);

  logic [15:0] elapsed;
  logic [15:0] next_elapsed;
  logic [7:1]  frac_hit;
  logic        full_hit;
  logic        early_hit;

  // ------------------------------------------------------------
  // fractional points 1/2 .. 1/256 of the interval
  // ------------------------------------------------------------
  genvar k;
  generate
    for (k = 1; k <= 7; k++) begin : g_frac
      // point T/2^k counts while k <= setting; a zero point is dropped
      assign frac_hit[k] = (inc_avg >= 3'(k)) && ((interval >> k) != 16'h0000) &&
                           (next_elapsed == (interval >> k));
    end
  endgenerate

  // 1/256 lies below the 1/128 loop bound, checked on its own
  logic hit_256;
  assign hit_256 = (inc_avg == 3'h7) && ((interval >> 8) != 16'h0000) &&
                   (next_elapsed == (interval >> 8));

  // zero interval never updates; software must not program it
  assign full_hit  = ms_tick && (interval != 16'h0000) && (next_elapsed >= interval);
  assign early_hit = ms_tick && !first_done && ((|frac_hit) || hit_256);
  assign next_elapsed = elapsed + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed    <= 16'h0000;
      update     <= 1'b0;
      first_done <= 1'b0;
    end else if (restart) begin
      elapsed    <= 16'h0000;
      update     <= 1'b0;
      first_done <= 1'b0;
    end else begin
      update <= full_hit || early_hit;
      if (full_hit) begin
        elapsed    <= 16'h0000;
        first_done <= 1'b1;
      end else if (ms_tick) begin
        elapsed <= next_elapsed;
      end
    end
  end

endmodule

`default_nettype wire

// ==== include/dph_pkg.sv ====
// package: register map, field layout, reset values and timing for the dpll history/phase block
package dph_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS         = 1000000;
  localparam int US_NS         = 1000;
  // exact divisions, so rounding up or down gives the same count
  localparam int MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int US_CYCLES_INT = (US_NS / CLK_PERIOD_NS < 1) ? 1 : US_NS / CLK_PERIOD_NS;
  localparam logic [3:0] US_CYCLES = 4'(US_CYCLES_INT);

  // ------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [13:0] IDX_HIST_TMR_LO = 14'h040b;
  localparam logic [13:0] IDX_HIST_TMR_HI = 14'h040c;
  localparam logic [13:0] IDX_HIST_MODE   = 14'h040d;
  localparam logic [13:0] IDX_FIX_PH_B0   = 14'h040e;
  localparam logic [13:0] IDX_FIX_PH_B1   = 14'h040f;
  localparam logic [13:0] IDX_FIX_PH_B2   = 14'h0410;
  localparam logic [13:0] IDX_FIX_PH_B3   = 14'h0411;
  localparam logic [13:0] IDX_STEP_LO     = 14'h0412;
  localparam logic [13:0] IDX_STEP_HI     = 14'h0413;
  localparam logic [13:0] IDX_SLEW_LO     = 14'h0414;
  localparam logic [13:0] IDX_SLEW_HI     = 14'h0415;
  localparam logic [13:0] IDX_STATUS      = 14'h0418;
  localparam logic [13:0] IDX_HOLD_B0     = 14'h0419;
  localparam logic [13:0] IDX_HOLD_B1     = 14'h041a;
  localparam logic [13:0] IDX_HOLD_B2     = 14'h041b;
  localparam logic [13:0] IDX_HOLD_B3     = 14'h041c;

  // ------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------
  localparam int FALLBACK_BIT = 4;
  localparam int PERSIST_BIT  = 3;
  localparam int INCAVG_LSB   = 0;
  localparam int INCAVG_W     = 3;
  localparam logic [7:0] MODE_MASK   = 8'h1f;
  localparam logic [7:0] TOP6_MASK   = 8'h3f;
  localparam int ST_HIST_VALID_BIT   = 0;
  localparam int ST_FIRST_DONE_BIT   = 1;
  localparam int ST_SLEWING_BIT      = 2;
  localparam int ST_HOLD_SRC_LSB     = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [15:0] HIST_TMR_RST = 16'h000a;
  localparam logic [7:0]  HIST_MODE_RST = 8'h00;
  localparam logic [29:0] FIX_PH_RST   = 30'h00000000;
  localparam logic [15:0] STEP_RST     = 16'h0000;
  localparam logic [15:0] SLEW_RST     = 16'h0000;

  // ------------------------------------------------------------
  // enumerations and carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DPH_SRC_NONE    = 2'b00,
    DPH_SRC_HISTORY = 2'b01,
    DPH_SRC_FREERUN = 2'b10,
    DPH_SRC_LOOP    = 2'b11
  } dph_hold_src_t;

  typedef struct packed {
    logic       fallback;
    logic       persist;
    logic [2:0] inc_avg;
  } dph_hist_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [29:0] word;
  } dph_tword_t;

endpackage

// ==== verification/dph_ctrl_checker.sv ====
// assertion checker for the dpll holdover history and phase control block
`timescale 1ns/1ps
`default_nettype none

module dph_ctrl_checker #(
  parameter int unsigned MS_CYCLES = dph_pkg::MS_CYCLES_DEF  // clocks per millisecond
) (
  input wire logic                   pclk,          // system clock
  input wire logic                   presetn,       // async reset, active low
  input wire logic                   psel,          // apb select
  input wire logic                   penable,       // apb enable
  input wire logic [15:0]            paddr,         // apb byte address
  input wire logic                   pready,        // apb ready
  input wire logic [31:0]            prdata,        // apb read data
  input wire logic                   pslverr,       // apb error
  input wire logic [29:0]            free_run_word, // stored free-running word
  input wire logic                   hold_enter,    // holdover entry pulse
  input wire logic [29:0]            hold_word,     // holdover word
  input wire dph_pkg::dph_hold_src_t hold_src,      // holdover word source
  input wire logic                   hist_valid,    // history exists
  input wire logic                   hist_update,   // history refresh pulse
  input wire logic [29:0]            phase_offset   // slewed offset
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ------------------------------------------------------------
  // register bus, holdover, history update and reset checks
  // ------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    penable && !pready ##1 penable && pready;
  endsequence

  a_apb_wait_state: assert property (s_setup |=> s_access)
    else $error("apb answer not on second access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_unaligned: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned access without error");
  a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_update_single: assert property (hist_update |=> !hist_update)
    else $error("history update longer than one cycle");
  a_hold_history: assert property (hold_enter && hist_valid |=> hold_src == dph_pkg::DPH_SRC_HISTORY)
    else $error("holdover ignored valid history");
  a_hold_freerun: assert property (
    hold_enter ##1 hold_src == dph_pkg::DPH_SRC_FREERUN |-> hold_word == $past(free_run_word))
    else $error("free-run holdover word mismatch");
  a_word_capture: assert property ($changed(hold_word) |-> $past(hold_enter))
    else $error("holdover word changed without holdover entry");
  a_reset_quiet: assert property (
    $rose(presetn) |-> hold_src == dph_pkg::DPH_SRC_NONE && !hist_valid && phase_offset == 30'h0)
    else $error("outputs not idle after reset");
endmodule

bind dph_ctrl dph_ctrl_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .free_run_word(free_run_word), .hold_enter(hold_enter),
  .hold_word(hold_word), .hold_src(hold_src), .hist_valid(hist_valid),
  .hist_update(hist_update), .phase_offset(phase_offset));

`default_nettype wire

// ==== verification/dph_ctrl_tb.sv ====
// self-checking bench for the dpll holdover history and phase control block
`timescale 1ns/1ps
`default_nettype none

module dph_ctrl_tb;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        ref_switch = 1'b0, hold_enter = 1'b0, loop_locked = 1'b0, step_up = 1'b0;
  logic        step_down = 1'b0, pready, pslverr, hist_valid, hist_update, slewing, er;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [29:0] free_run_word = 30'h01234567, hold_word, phase_offset;
  logic [7:0]  rd;
  int          failures = 0, cmp_count = 0;
  dph_pkg::dph_tword_t    loop_tword = '{1'b0, 30'h2aaaaaaa};
  dph_pkg::dph_hold_src_t hold_src;

  always #50 pclk = ~pclk;

  dph_ctrl #(.MS_CYCLES(20)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .loop_tword(loop_tword), .free_run_word(free_run_word),
    .ref_switch(ref_switch), .hold_enter(hold_enter), .loop_locked(loop_locked),
    .step_up(step_up), .step_down(step_down), .hold_word(hold_word), .hold_src(hold_src),
    .hist_valid(hist_valid), .hist_update(hist_update), .phase_offset(phase_offset),
    .slewing(slewing));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) failures++;
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] ix, input logic [7:0] d);
    apb(1'b1, {ix, 2'b00}, d);
  endtask

  task automatic rdc(input logic [13:0] ix, input logic [7:0] e);
    apb(1'b0, {ix, 2'b00}, 8'h00);
    chk(rd, e);
  endtask

  // one-cycle pulse: 0 holdover entry, 1 reference switch, 2 step up, 3 step down
  task automatic pulse(input int s);
    @(posedge pclk);
    if (s == 0) hold_enter <= 1'b1;
    else if (s == 1) ref_switch <= 1'b1;
    else if (s == 2) step_up <= 1'b1;
    else step_down <= 1'b1;
    @(posedge pclk);
    hold_enter <= 1'b0;
    ref_switch <= 1'b0;
    step_up    <= 1'b0;
    step_down  <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 11; i++) begin
      rdc(dph_pkg::IDX_HIST_TMR_LO + 14'(i), (i == 0) ? 8'h0a : 8'h00);
    end
    chk(phase_offset, 30'h0);
    $display("t_reset done");
  endtask

  // must run within the first averaging interval, before any history exists
  task automatic t_hold;
    pulse(0);
    chk(hold_src, dph_pkg::DPH_SRC_FREERUN);
    chk(hold_word, 30'h01234567);
    loop_tword.valid <= 1'b1;
    wr(dph_pkg::IDX_HIST_MODE, 8'h10);
    pulse(0);
    chk(hold_src, dph_pkg::DPH_SRC_LOOP);
    chk(hold_word, 30'h2aaaaaaa);
    $display("t_hold done");
  endtask

  task automatic t_regs;
    wr(dph_pkg::IDX_HIST_MODE, 8'hff);
    rdc(dph_pkg::IDX_HIST_MODE, 8'h1f);
    wr(dph_pkg::IDX_FIX_PH_B3, 8'hff);
    rdc(dph_pkg::IDX_FIX_PH_B3, 8'h3f);
    apb(1'b1, 16'h1035, 8'h00);
    chk(er, 1'b1);
    apb(1'b0, 16'h0004, 8'h00);
    chk({er, rd}, 9'h100);
    wr(dph_pkg::IDX_HIST_MODE, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_phase;
    wr(dph_pkg::IDX_FIX_PH_B0, 8'hf0);
    wr(dph_pkg::IDX_FIX_PH_B1, 8'hde);
    wr(dph_pkg::IDX_FIX_PH_B2, 8'hbc);
    wr(dph_pkg::IDX_FIX_PH_B3, 8'h3a);
    repeat (3) @(posedge pclk);
    chk(phase_offset, 30'h3abcdef0);
    wr(dph_pkg::IDX_STEP_LO, 8'h05);
    pulse(2);
    chk(phase_offset, 30'h3abcdef0);
    loop_locked <= 1'b1;
    pulse(2);
    chk(phase_offset, 30'h3abcdef5);
    pulse(3);
    chk(phase_offset, 30'h3abcdef0);
    // 310 us/s is the smallest useful nonzero limit
    wr(dph_pkg::IDX_SLEW_LO, 8'h36);
    wr(dph_pkg::IDX_SLEW_HI, 8'h01);
    wr(dph_pkg::IDX_FIX_PH_B1, 8'h00);
    repeat (20) @(posedge pclk);
    chk(slewing, 1'b1);
    chk(phase_offset !== 30'h3abc00f0, 1'b1);
    wr(dph_pkg::IDX_SLEW_LO, 8'h00);
    wr(dph_pkg::IDX_SLEW_HI, 8'h00);
    repeat (3) @(posedge pclk);
    chk({slewing, phase_offset}, {1'b0, 30'h3abc00f0});
    $display("t_phase done");
  endtask

  task automatic t_hist;
    int n;
    int e [4];
    e = '{3, 4, 5, 6};
    for (int k = 0; k < 4; k++) begin
      wr(dph_pkg::IDX_HIST_MODE, 8'(k));
      pulse(1);
      n = 0;
      repeat (700) begin
        @(posedge pclk);
        if (hist_update === 1'b1) n++;
      end
      chk(n, e[k]);
    end
    pulse(0);
    chk(hold_src, dph_pkg::DPH_SRC_HISTORY);
    chk(hold_word, 30'h2aaaaaaa);
    rdc(dph_pkg::IDX_STATUS, 8'h0b);
    rdc(dph_pkg::IDX_HOLD_B3, 8'h2a);
    wr(dph_pkg::IDX_HIST_MODE, 8'h08);
    pulse(1);
    chk(hist_valid, 1'b1);
    wr(dph_pkg::IDX_HIST_MODE, 8'h00);
    pulse(1);
    chk(hist_valid, 1'b0);
    $display("t_hist done");
  endtask

  task automatic complete_run;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hold();
    t_regs();
    t_phase();
    t_hist();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    complete_run();
  end
endmodule

`default_nettype wire
